// ==== hdl/spm_pkg.sv ====
// Shared constants and types for the self-programming flash controller
package spm_pkg;
	// Control/status bit positions
	localparam int READY_IRQ_ENABLE_BIT    = 7;
	localparam int RW_SECTION_BUSY_BIT     = 6;
	localparam int SIGNATURE_READ_BIT      = 5;
	localparam int RW_SECTION_REENABLE_BIT = 4;
	localparam int BOOT_LOCK_SET_BIT       = 3;
	localparam int PAGE_WRITE_CMD_BIT      = 2;
	localparam int PAGE_ERASE_CMD_BIT      = 1;
	localparam int STORE_PROG_ENABLE_BIT   = 0;
	localparam logic [7:0] CSR_RESET       = 8'h00;
	// Accepted command patterns on bits 5:0; bit 5 marks the signature read
	localparam logic [5:0] PAT_SIG    = 6'h21;
	localparam logic [5:0] PAT_REEN   = 6'h11;
	localparam logic [5:0] PAT_LOCK   = 6'h09;
	localparam logic [5:0] PAT_WRITE  = 6'h05;
	localparam logic [5:0] PAT_ERASE  = 6'h03;
	localparam logic [5:0] PAT_FILL   = 6'h01;
	// Command window lengths in cycles
	localparam logic [2:0] STORE_WINDOW = 3'h4;
	localparam logic [2:0] LOAD_WINDOW  = 3'h3;
	// Geometry: largest variant, 16-bit word counter
	localparam int PAGE_WORDS    = 128;
	localparam int WORD_BITS     = 7;
	localparam int PAGE_BITS     = 9;
	localparam int PAGE_BITS_32K = 8;
	localparam logic [15:0] NO_RW_START     = 16'hF000;
	localparam logic [15:0] RW_END          = 16'hEFFF;
	localparam logic [14:0] NO_RW_START_32K = 15'h7000;
	localparam logic [14:0] RW_END_32K      = 15'h6FFF;
	// Boot reset addresses per fuse code 11/10/01/00
	localparam logic [15:0] BOOT_ADDR_11 = 16'hFE00;
	localparam logic [15:0] BOOT_ADDR_10 = 16'hFC00;
	localparam logic [15:0] BOOT_ADDR_01 = 16'hF800;
	localparam logic [15:0] BOOT_ADDR_00 = 16'hF000;
	// Flash operation time, in ns, and derived cycles at 50 MHz
	localparam int CLK_PERIOD_NS = 20;
	localparam int PROG_TIME_NS  = 2000;
	localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// APB register offsets
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_RESULT = 8'h08;
	localparam int SIGNATURE_DEFAULT = 8'h5A; // arbitrary value
endpackage

// ==== hdl/spm_if.sv ====
// Interface between the core-side issuer and the flash controller
`timescale 1ns/1ps
`default_nettype none
interface spm_if;
	logic        csrWrite;    // write control/status
	logic [7:0]  csrWdata;
	logic [7:0]  csrRdata;
	logic        globalIe;    // core global interrupt flag
	logic        storeInstr;  // store-program instruction, one cycle
	logic        loadInstr;   // load-program instruction, one cycle
	logic [16:0] pointer;
	logic [7:0]  dataLow;
	logic [7:0]  dataHigh;
	logic [7:0]  loadData;
	logic        loadValid;
	logic        coreHalt;
	logic        readyIrq;
	modport device (input csrWrite, csrWdata, globalIe, storeInstr, loadInstr, pointer, dataLow, dataHigh,
		output csrRdata, loadData, loadValid, coreHalt, readyIrq);
	modport core (output csrWrite, csrWdata, globalIe, storeInstr, loadInstr, pointer, dataLow, dataHigh,
		input csrRdata, loadData, loadValid, coreHalt, readyIrq);
endinterface
`default_nettype wire

// ==== hdl/self_program_flash_control.sv ====
// Device end: self-programming flash controller with page buffer
// Behaviour
// - Boot fuses pick boot size and start
// - Words below F000 (7000 on the smaller variant) are read-while-write section
// - Page from pointer 16:8, word 7:1
// - Smaller variant uses pointer 15:8 pages
// - Pages hold 128 words; index zero
// - Pointer bit 0 selects load byte
// - Ready interrupt while enable bit clear
// - Erase/write to section sets busy flag
// - Busy clears on re-enable or fill
// - Signature read; store then does nothing
// - Re-enable only after programming done
// - Re-enable during fill clears the fill flag; buffer contents kept
// - Lock-set programs boot lock bits
// - Lock-set load reads lock or fuse
// - Page write from buffer, auto-clear
// - Page erase, auto-clear
// - Halt core for protected-section page programming
// - Plain enable fills buffer word
// - Enable lasts four cycles or operation
// - Only six command patterns are accepted
// - One store operation at a time
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module self_program_flash_control (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	spm_if.device            core,
	input  wire logic        bootSizeFuseHi,
	input  wire logic        bootSizeFuseLo,
	input  wire logic        smallVariant,
	input  wire logic [7:0]  fuseByte,
	output logic [15:0]      bootResetAddr,
	output logic [15:0]      appSectionEnd,
	output logic             rwSectionBlocked,
	output logic [7:0]       bootLockBits,
	output logic [7:0]       bufWord0Low,
	output logic             flashWrite,
	output logic             flashErase,
	output logic [8:0]       flashPage
);
	typedef enum {IDLE, PROG} op_state_type;
	op_state_type     state,        next_state;
	logic [7:0]       csr,          next_csr;
	logic [2:0]       storeWin,     next_storeWin;
	logic [2:0]       loadWin,      next_loadWin;
	logic [15:0]      progCount,    next_progCount;
	logic             haltTarget,   next_haltTarget;
	logic             halt,         next_halt;
	logic [15:0]      appEnd,       next_appEnd;
	logic             filling,      next_filling;
	logic [7:0]       lockBits,     next_lockBits;
	logic [7:0]       loadData,     next_loadData;
	logic             loadValid,    next_loadValid;
	logic [15:0]      bootAddr,     next_bootAddr;
	logic [8:0]       page,         next_page;
	logic             doWrite,      next_doWrite;
	logic             doErase,      next_doErase;
	logic             readyIrq,     next_readyIrq;
	logic [15:0]      pageBuf [0:spm_pkg::PAGE_WORDS-1];
	logic [15:0]      flashMem [0:255];

	// Page number from pointer for either variant
	function automatic logic [8:0] page_of(input logic [16:0] z, input logic isSmall);
		page_of = isSmall ? {1'b0, z[15:8]} : z[16:8];
	endfunction

	// Page lies in the no-read-while-write section
	function automatic logic in_no_rw(input logic [8:0] pg, input logic isSmall);
		in_no_rw = isSmall ? ({pg[7:0], 7'h00} >= spm_pkg::NO_RW_START_32K)
			: ({pg, 7'h00} >= spm_pkg::NO_RW_START);
	endfunction

	// Next-state logic for the command sequencer
	always_comb begin
		next_state      = state;
		next_csr        = csr;
		next_storeWin   = storeWin;
		next_loadWin    = loadWin;
		next_progCount  = progCount;
		next_haltTarget = haltTarget;
		next_filling    = filling;
		next_lockBits   = lockBits;
		next_loadData   = loadData;
		next_loadValid  = 1'b0;
		next_page       = page;
		next_doWrite    = 1'b0;
		next_doErase    = 1'b0;
		case ({bootSizeFuseHi, bootSizeFuseLo})
			2'b11: next_bootAddr = spm_pkg::BOOT_ADDR_11;
			2'b10: next_bootAddr = spm_pkg::BOOT_ADDR_10;
			2'b01: next_bootAddr = spm_pkg::BOOT_ADDR_01;
			default: next_bootAddr = spm_pkg::BOOT_ADDR_00;
		endcase
		// Registered so the end address comes straight off a flip-flop
		next_appEnd = next_bootAddr - 16'h0001;
		// Window countdowns; on store-window expiry command bits drop
		if (state == IDLE && storeWin != 3'h0) begin
			next_storeWin = storeWin - 3'h1;
			if (storeWin == 3'h1)
				next_csr[5:0] = 6'h00;
		end
		if (loadWin != 3'h0)
			next_loadWin = loadWin - 3'h1;
		// Software write: ignored while programming is busy
		if (core.csrWrite && state == IDLE) begin
			next_csr[spm_pkg::READY_IRQ_ENABLE_BIT] = core.csrWdata[spm_pkg::READY_IRQ_ENABLE_BIT];
			if (core.csrWdata[spm_pkg::RW_SECTION_REENABLE_BIT] && filling)
				next_filling = 1'b0;
			case (core.csrWdata[5:0])
				spm_pkg::PAT_SIG, spm_pkg::PAT_REEN, spm_pkg::PAT_LOCK,
				spm_pkg::PAT_WRITE, spm_pkg::PAT_ERASE, spm_pkg::PAT_FILL: begin
					next_csr[5:0] = core.csrWdata[5:0];
					next_storeWin = spm_pkg::STORE_WINDOW;
					next_loadWin  = spm_pkg::LOAD_WINDOW;
				end
				default: ;
			endcase
		end
		if (core.loadInstr && loadWin != 3'h0 && csr[0]) begin
			next_loadValid = 1'b1;
			if (csr[spm_pkg::SIGNATURE_READ_BIT])
				next_loadData = spm_pkg::SIGNATURE_DEFAULT[7:0];
			else if (csr[spm_pkg::BOOT_LOCK_SET_BIT])
				next_loadData = core.pointer[0] ? fuseByte : lockBits;
		end
		case (state)
			IDLE: begin
				if (core.storeInstr && storeWin != 3'h0 && csr[0]) begin
					next_storeWin = 3'h0;
					next_csr[5:0] = 6'h00;
					if (csr[spm_pkg::SIGNATURE_READ_BIT]) begin
					end else if (csr[spm_pkg::RW_SECTION_REENABLE_BIT]) begin
						next_csr[spm_pkg::RW_SECTION_BUSY_BIT] = 1'b0;
					end else if (csr[spm_pkg::BOOT_LOCK_SET_BIT]) begin
						next_lockBits = core.dataLow;
					end else if (csr[2] | csr[1]) begin
						// page erase or page write
						// Page latched only here, so ignored stores leave it alone
						next_page       = page_of(core.pointer, smallVariant);
						next_haltTarget = in_no_rw(page_of(core.pointer, smallVariant), smallVariant);
						if (!in_no_rw(page_of(core.pointer, smallVariant), smallVariant))
							next_csr[spm_pkg::RW_SECTION_BUSY_BIT] = 1'b1;
						next_csr[2:0]  = csr[2:0];
						next_progCount = 16'(spm_pkg::PROG_CYCLES);
						next_doWrite   = csr[2];
						next_doErase   = csr[1];
						next_filling   = 1'b0;
						next_state     = PROG;
					end else begin
						next_filling = 1'b1;
						next_csr[spm_pkg::RW_SECTION_BUSY_BIT] = 1'b0;
					end
				end
			end
			PROG: begin
				if (progCount == 16'h0001) begin
					next_csr[2:0] = 3'h0;
					next_state    = IDLE;
				end
				next_progCount = progCount - 16'h0001;
			end
			default: next_state = IDLE;
		endcase
		next_readyIrq = next_csr[spm_pkg::READY_IRQ_ENABLE_BIT] && core.globalIe && !next_csr[0];
		// halt registered from the next state
		next_halt = (next_state == PROG) && next_haltTarget;
	end

	// Registers; reset cancels windows and commands
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state      <= IDLE;
			csr        <= spm_pkg::CSR_RESET;
			storeWin   <= 3'h0;
			loadWin    <= 3'h0;
			progCount  <= 16'h0000;
			haltTarget <= 1'b0;
			halt       <= 1'b0;
			appEnd     <= 16'h0000;
			filling    <= 1'b0;
			lockBits   <= 8'hFF;
			loadData   <= 8'h00;
			loadValid  <= 1'b0;
			bootAddr   <= 16'h0000;
			page       <= 9'h000;
			doWrite    <= 1'b0;
			doErase    <= 1'b0;
			readyIrq   <= 1'b0;
		end else if (clkEn) begin
			state      <= next_state;
			csr        <= next_csr;
			storeWin   <= next_storeWin;
			loadWin    <= next_loadWin;
			progCount  <= next_progCount;
			haltTarget <= next_haltTarget;
			halt       <= next_halt;
			appEnd     <= next_appEnd;
			filling    <= next_filling;
			lockBits   <= next_lockBits;
			loadData   <= next_loadData;
			loadValid  <= next_loadValid;
			bootAddr   <= next_bootAddr;
			page       <= next_page;
			doWrite    <= next_doWrite;
			doErase    <= next_doErase;
			readyIrq   <= next_readyIrq;
		end
	end

	// Buffer and array storage; no reset, contents are data
	always_ff @(posedge mclk) begin
		if (clkEn && state == IDLE && core.storeInstr && storeWin != 3'h0 && csr[5:0] == spm_pkg::PAT_FILL)
			pageBuf[core.pointer[7:1]] <= {core.dataHigh, core.dataLow};
		if (clkEn && doWrite)
			flashMem[page[7:0]] <= pageBuf[0];
	end

	// Outputs straight from flip-flops
	assign core.csrRdata  = csr;
	assign core.loadData  = loadData;
	assign core.loadValid = loadValid;
	assign core.coreHalt  = halt;
	assign core.readyIrq  = readyIrq;
	assign bootResetAddr    = bootAddr;
	assign appSectionEnd    = appEnd;
	assign rwSectionBlocked = csr[spm_pkg::RW_SECTION_BUSY_BIT];
	assign bootLockBits     = lockBits;
	assign bufWord0Low      = pageBuf[0][7:0];
	assign flashWrite       = doWrite;
	assign flashErase       = doErase;
	assign flashPage        = page;
endmodule
`default_nettype wire

// ==== hdl/spm_core_master.sv ====
// Core end: APB command registers driving store/load instructions
`timescale 1ns/1ps
`default_nettype none
module spm_core_master (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	spm_if.core              dev,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	logic [31:0] rdata,   next_rdata;
	logic        rdy,     next_rdy;
	logic        err,     next_err;
	logic        wr,      next_wr;
	logic [7:0]  wdat,    next_wdat;
	logic        st,      next_st;
	logic        ld,      next_ld;
	logic        gie,     next_gie;
	logic [16:0] ptr,     next_ptr;
	logic [15:0] dat,     next_dat;
	logic [7:0]  result,  next_result;

	// APB slave; command word fires one pulse per write
	always_comb begin
		next_rdata  = 32'h00000000;
		next_rdy    = 1'b0;
		next_err    = 1'b0;
		next_wr     = 1'b0;
		next_wdat   = wdat;
		next_st     = 1'b0;
		next_ld     = 1'b0;
		next_gie    = gie;
		next_ptr    = ptr;
		next_dat    = dat;
		next_result = dev.loadValid ? dev.loadData : result;
		if (psel && penable && !rdy) begin
			next_rdy = 1'b1;
			case (paddr)
				spm_pkg::OFS_CMD: begin
					// Bits: 7:0 csr, 8 write csr, 9 store, 10 load, 11 gie
					if (pwrite) begin
						next_wdat = pwdata[7:0];
						next_wr   = pwdata[8];
						next_st   = pwdata[9];
						next_ld   = pwdata[10];
						next_gie  = pwdata[11];
					end
					next_rdata = {20'h00000, gie, 3'h0, dev.csrRdata};
				end
				spm_pkg::OFS_STATUS: begin
					// Pointer in 16:0, data word above
					if (pwrite) begin
						next_ptr = pwdata[16:0];
						next_dat = {pwdata[31:24], 8'h00} | {8'h00, pwdata[24:17]};
					end
					next_rdata = {15'h0000, ptr};
				end
				spm_pkg::OFS_RESULT: next_rdata = {22'h000000, dev.readyIrq, dev.coreHalt, result};
				default: next_err = 1'b1;
			endcase
		end
	end

	// Registers only
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h00000000;
			rdy <= 1'b0;
			err <= 1'b0;
			wr <= 1'b0;
			wdat <= 8'h00;
			st <= 1'b0;
			ld <= 1'b0;
			gie <= 1'b0;
			ptr <= 17'h00000;
			dat <= 16'h0000;
			result <= 8'h00;
		end else if (clkEn) begin
			rdata <= next_rdata;
			rdy <= next_rdy;
			err <= next_err;
			wr <= next_wr;
			wdat <= next_wdat;
			st <= next_st;
			ld <= next_ld;
			gie <= next_gie;
			ptr <= next_ptr;
			dat <= next_dat;
			result <= next_result;
		end
	end

	assign prdata         = rdata;
	assign pready         = rdy;
	assign pslverr        = err;
	assign dev.csrWrite   = wr;
	assign dev.csrWdata   = wdat;
	assign dev.storeInstr = st;
	assign dev.loadInstr  = ld;
	assign dev.globalIe   = gie;
	assign dev.pointer    = ptr;
	assign dev.dataLow    = dat[7:0];
	assign dev.dataHigh   = dat[15:8];
endmodule
`default_nettype wire

// ==== sim/spm_assertions.sv ====
// Checker on the link between core end and controller end
`timescale 1ns/1ps
`default_nettype none
module spm_assertions (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       csrWrite,
	input wire logic [7:0] csrWdata,
	input wire logic [7:0] csrRdata,
	input wire logic       globalIe,
	input wire logic       loadInstr,
	input wire logic       loadValid,
	input wire logic       coreHalt,
	input wire logic       readyIrq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	logic irqCause;
	logic goodPat;
	// Cause held two cycles, since the interrupt is a registered copy
	assign irqCause = csrRdata[7] && globalIe && !csrRdata[0];
	assign goodPat  = csrWdata[4:0] inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01};
	a_irq_on: assert property (irqCause [*2] |-> readyIrq)
		else $error("ready interrupt missing");
	a_irq_off: assert property (!irqCause [*2] |-> !readyIrq)
		else $error("ready interrupt without cause");
	a_load_answer: assert property (loadValid |-> $past(loadInstr))
		else $error("load data without load");
	a_fill_window: assert property ($rose(csrRdata[0]) && csrRdata[2:1] == 2'b00 |-> ##[1:6] !csrRdata[0])
		else $error("enable outlived window");
	a_prog_clear: assert property ($rose(csrRdata[0]) && csrRdata[2:1] != 2'b00
		|-> ##[1:150] csrRdata[2:0] == 3'b000)
		else $error("program bits stuck");
	a_lock_clear: assert property ($rose(csrRdata[0]) && csrRdata[3] |-> ##[1:6] !csrRdata[3])
		else $error("lock set bit stuck");
	a_halt_only: assert property (coreHalt |-> csrRdata[0] && csrRdata[2:1] != 2'b00)
		else $error("halt outside programming");
	a_busy_start: assert property ($rose(csrRdata[6]) |-> csrRdata[0])
		else $error("busy set without operation");
	a_bad_pattern: assert property (csrWrite && !goodPat && !csrRdata[0] |=> csrRdata[4:0] == 5'h00)
		else $error("bad pattern took effect");
	a_busy_refuse: assert property (csrWrite && csrRdata[0] && csrRdata[2:1] != 2'b00 |=> !csrRdata[4])
		else $error("re-enable taken while busy");
endmodule
`default_nettype wire

// ==== sim/self_program_flash_control_tb_top.sv ====
// Bench joining both controller ends, driven over APB
`timescale 1ns/1ps
`default_nettype none
module self_program_flash_control_tb_top;
	logic        mclk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        fuseHi;
	logic        fuseLo;
	logic        smallVar;
	logic        run;
	logic [7:0]  bufLow;
	logic [7:0]  fuseByte;
	logic [15:0] bootAddr;
	logic [15:0] appEnd;
	logic        blocked;
	logic [7:0]  lockBits;
	logic        flashWrite;
	logic        flashErase;
	logic [8:0]  flashPage;
	logic [8:0]  lastPage;
	logic [1:0]  lastKind;
	logic [31:0] rd;
	logic        slvErr;
	logic        held;
	logic [7:0]  r;
	logic [4:0]  p5;
	int          errors;
	int          checkCount;
	int          pulses;
	int          n0;
	spm_if bus();
	self_program_flash_control u_self_program_flash_control (.mclk(mclk), .rst(rst), .clkEn(run), .core(bus),
		.bootSizeFuseHi(fuseHi), .bootSizeFuseLo(fuseLo), .smallVariant(smallVar), .fuseByte(fuseByte),
		.bootResetAddr(bootAddr), .appSectionEnd(appEnd), .rwSectionBlocked(blocked), .bootLockBits(lockBits),
		.bufWord0Low(bufLow), .flashWrite(flashWrite), .flashErase(flashErase), .flashPage(flashPage));
	spm_core_master u_spm_core_master (.mclk(mclk), .rst(rst), .clkEn(run), .dev(bus), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	spm_assertions u_spm_assertions (.mclk(mclk), .rst(rst), .csrWrite(bus.csrWrite), .csrWdata(bus.csrWdata),
		.csrRdata(bus.csrRdata), .globalIe(bus.globalIe), .loadInstr(bus.loadInstr), .loadValid(bus.loadValid),
		.coreHalt(bus.coreHalt), .readyIrq(bus.readyIrq));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Flash start pulses, counted so stray operations show
	always @(posedge mclk) if (flashWrite === 1'b1 || flashErase === 1'b1) begin
		pulses <= pulses + 1;
		lastPage <= flashPage;
		lastKind <= {flashWrite, flashErase};
	end
	function automatic logic [15:0] bootFor(int c);
		return 16'(32'h10000 - (32'h200 << c));
	endfunction
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	// Entered just after an edge; psel stays up when another transfer follows
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic more);
		if (!held) psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		slvErr = pslverr;
		penable <= 1'b0;
		held = more;
		if (!more) begin
			psel <= 1'b0;
			@(posedge mclk);
		end
	endtask
	// Pointer and data, command, then store or load right behind it
	task automatic op(input logic [16:0] p, input logic [7:0] dh, input logic [6:0] dl, input logic [5:0] pat,
		input logic ld);
		apb(1'b1, spm_pkg::OFS_STATUS, {dh, dl, p}, 1'b0);
		apb(1'b1, spm_pkg::OFS_CMD, {23'h0, 1'b1, 2'b00, pat}, 1'b1);
		apb(1'b1, spm_pkg::OFS_CMD, ld ? 32'h400 : 32'h200, 1'b0);
	endtask
	// next operation only after the enable bit clears
	task automatic waitIdle();
		do @(posedge mclk); while (bus.csrRdata[0] !== 1'b0);
	endtask
	// pointers used here keep the word index at zero
	task automatic prog(input logic [16:0] p, input logic [5:0] pat);
		n0 = pulses;
		op(p, 8'h00, 7'h00, pat, 1'b0);
		do @(posedge mclk); while (pulses == n0);
	endtask
	task automatic ldChk(input logic [16:0] p, input logic [5:0] pat);
		op(p, 8'h00, 7'h00, pat, 1'b1);
		apb(1'b0, spm_pkg::OFS_RESULT, 32'h0, 1'b0);
	endtask
	task automatic conclude();
		$display("errors %0d checks %0d", errors, checkCount);
		if (errors == 0 && checkCount > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hang guard, far beyond the expected run
	initial begin
		#400000;
		errors++;
		conclude();
	end
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata, held} = {1'b1, 44'h0};
		{errors, checkCount, pulses, fuseHi, fuseLo, smallVar} = 0;
		run = 1'b1;
		r = 8'($urandom(74));
		fuseByte = 8'($urandom);
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		check("csr", bus.csrRdata, 8'h00);
		check("lock", lockBits, 8'hFF);
		for (int i = 0; i < 4; i++) begin
			{fuseHi, fuseLo} <= 2'(3 - i);
			repeat (2) @(posedge mclk);
			check("boot", bootAddr, bootFor(i));
			check("appEnd", appEnd, bootFor(i) - 16'h0001);
		end
		apb(1'b0, 8'h0C, 32'h0, 1'b0);
		check("slverr", slvErr, 1'b1);
		// Fill then write the first page of the protected section
		op(17'h1E000, r, r[6:0], spm_pkg::PAT_FILL, 1'b0);
		waitIdle();
		check("buf", bufLow, {r[0], r[6:0]});
		prog(17'h1E000, spm_pkg::PAT_WRITE);
		check("page", lastPage, 9'h1E0);
		check("kind", lastKind, 2'b10);
		check("halt", bus.coreHalt, 1'b1);
		check("busy", bus.csrRdata[6], 1'b0);
		waitIdle();
		check("halt", bus.coreHalt, 1'b0);
		check("bits", bus.csrRdata[2:0], 3'b000);
		// Smaller variant ignores pointer bit 16
		smallVar <= 1'b1;
		prog(17'h10500, spm_pkg::PAT_ERASE);
		check("page", lastPage, 9'h005);
		check("kind", lastKind, 2'b01);
		check("busy", bus.csrRdata[6], 1'b1);
		check("block", blocked, 1'b1);
		check("halt", bus.coreHalt, 1'b0);
		// Clock enable low must freeze the running erase
		run <= 1'b0;
		repeat (8) @(posedge mclk);
		check("frozen", bus.csrRdata[2:0], 3'b011);
		run <= 1'b1;
		apb(1'b1, spm_pkg::OFS_CMD, {23'h0, 1'b1, 2'b00, spm_pkg::PAT_REEN}, 1'b0);
		waitIdle();
		check("refuse", bus.csrRdata[6], 1'b1);
		op(17'h10500, 8'h00, 7'h00, spm_pkg::PAT_FILL, 1'b0);
		waitIdle();
		check("fillClr", bus.csrRdata[6], 1'b0);
		// Last page below the boundary still counts as busy section
		smallVar <= 1'b0;
		prog(17'h1DF00, spm_pkg::PAT_ERASE);
		check("page", lastPage, 9'h1DF);
		check("busy", bus.csrRdata[6], 1'b1);
		waitIdle();
		op(17'h1DF00, 8'h00, 7'h00, spm_pkg::PAT_REEN, 1'b0);
		waitIdle();
		check("reen", bus.csrRdata[6], 1'b0);
		check("block", blocked, 1'b0);
		// Outer bits kept set so masked or direct lock models agree
		r = {2'b11, 4'($urandom), 2'b11};
		op(17'h00000, 8'h01, r[6:0], spm_pkg::PAT_LOCK, 1'b0);
		waitIdle();
		check("lockSet", lockBits, r);
		check("lockClr", bus.csrRdata[3], 1'b0);
		ldChk(17'h00000, spm_pkg::PAT_LOCK);
		check("lockRd", rd[7:0], r);
		ldChk(17'h00001, spm_pkg::PAT_LOCK);
		check("fuseRd", rd[7:0], fuseByte);
		ldChk(17'h00000, spm_pkg::PAT_SIG);
		check("sig", rd[7:0], 8'(spm_pkg::SIGNATURE_DEFAULT));
		// Signature store and stray patterns must start nothing
		n0 = pulses;
		op(17'h1E000, 8'h00, 7'h00, spm_pkg::PAT_SIG, 1'b0);
		for (int i = 0; i < 6; i++) begin
			do p5 = 5'($urandom); while (p5 inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01});
			op(17'h1E000, 8'h00, 7'h00, {1'b0, p5}, 1'b0);
		end
		waitIdle();
		check("stray", pulses, n0);
		check("lockKept", lockBits, r);
		apb(1'b1, spm_pkg::OFS_CMD, 32'h980, 1'b0);
		apb(1'b0, spm_pkg::OFS_RESULT, 32'h0, 1'b0);
		check("irq", rd[9], 1'b1);
		apb(1'b1, spm_pkg::OFS_CMD, 32'h180, 1'b0);
		apb(1'b0, spm_pkg::OFS_RESULT, 32'h0, 1'b0);
		check("irqOff", rd[9], 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
